// ==== design/pfpp_flash_port.sv ====
// Byte-wide parallel flash programming port with code, signature,
// lock, fuse and status access.
// Assumes pins are asynchronous and strobe pulses last several clocks.
`timescale 1ns/1ps
module pfpp_flash_port
  import pfpp_pkg::*;
#(
  parameter int PROG_CYCLES = WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Programmer pins
  input  wire logic       byte_strobe_pin,
  input  wire logic       select_pin_n,
  input  wire logic [7:0] byte_command_port_in,
  output logic      [7:0] byte_command_port_out,
  output logic            byte_command_port_oe_n,
  output logic            ready_busy_pin
);

  localparam pfpp_pins_type PINS_IDLE = '{strobe: 1'b0, select_n: 1'b1, data: 8'h00};

  pfpp_pins_type  pins;
  pfpp_state_type state;
  logic           strobe_last;
  logic           select_last;
  logic           rise;
  logic           fall;
  logic           select_rise;
  logic [2:0]     byte_count;
  logic [7:0]     command;
  logic [7:0]     addr_high;
  logic [PAGE_HI-PAGE_LO:0] page;
  logic [OFFSET_HI:0] offset;
  logic           enabled;
  logic           pending;
  logic [7:0]     held_byte;
  logic           busy;
  logic           prog_done;
  logic           prog_start;
  logic           success;
  logic [1:0]     lock_bits;
  logic [7:0]     fuses;
  logic [7:0]     status_byte;
  logic [7:0]     read_byte;
  logic           is_read;
  logic           accept;

  logic [7:0] code_mem  [CODE_BYTES];
  logic [7:0] user_row  [PAGE_BYTES];
  logic [7:0] maker_row [PAGE_BYTES];
  logic [7:0] page_buf  [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] buf_valid;

  pfpp_sync #(
    .WIDTH       (10),
    .RESET_VALUE (PINS_IDLE)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({byte_strobe_pin, select_pin_n, byte_command_port_in}),
    .sync_out (pins)
  );

  pfpp_busy_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .start (prog_start),
    .busy  (busy),
    .done  (prog_done)
  );

  // Maker row is fixed contents; arbitrary pattern
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_maker
      assign maker_row[gi] = MAKER_SIG_SEED + 8'(gi);
    end
  endgenerate

  // Command byte accepted only in an enabled session
  function automatic logic cmd_ok(input logic [7:0] c, input logic en,
                                  input logic bsy, input logic [7:0] fz);
    logic write_ok;
    write_ok = en & ~bsy;
    case (c)
      CMD_READ_CODE, CMD_READ_USER, CMD_READ_MAKER,
      CMD_READ_LOCK, CMD_READ_FUSE, CMD_READ_STATUS: cmd_ok = en;
      CMD_WRITE_CODE, CMD_WRITE_LOCK, CMD_WRITE_FUSE: cmd_ok = write_ok;
      CMD_WRITE_USER: cmd_ok = write_ok & ~fz[FUSE_USER_ROW_BIT];
      default: cmd_ok = 1'b0;
    endcase
  endfunction : cmd_ok

  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_last <= 1'b0;
      select_last <= 1'b1;
    end else begin
      strobe_last <= pins.strobe;
      select_last <= pins.select_n;
    end
  end

  assign rise        = pins.strobe & ~strobe_last & ~pins.select_n;
  assign fall        = ~pins.strobe & strobe_last & ~pins.select_n;
  assign select_rise = pins.select_n & ~select_last;
  assign accept      = cmd_ok(pins.data, enabled, busy, fuses);
  assign is_read     = (command == CMD_READ_CODE) || (command == CMD_READ_USER) ||
                       (command == CMD_READ_MAKER) || (command == CMD_READ_LOCK) ||
                       (command == CMD_READ_FUSE) || (command == CMD_READ_STATUS);

  // Frame sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else if (pins.select_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_PREAMBLE;
        end
        ST_PREAMBLE: begin
          if (rise) begin
            state <= (pins.data == PREAMBLE) ? ST_COMMAND : ST_IGNORE;
          end
        end
        ST_COMMAND: begin
          if (rise) begin
            if (pins.data == ENABLE_BYTE1) begin
              state <= ST_ENABLE;
            end else if (accept) begin
              state <= ST_ADDRESS;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ENABLE: begin
          if (rise) begin
            state <= ST_IGNORE;
          end
        end
        ST_ADDRESS: begin
          if (rise && byte_count == BYTE_ADDR_LO) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          state <= ST_DATA;
        end
        ST_IGNORE: begin
          state <= ST_IGNORE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Bytes seen in the current frame, saturating
  always_ff @(posedge clk) begin
    if (reset || pins.select_n) begin
      byte_count <= '0;
    end else if (rise && byte_count != BYTE_COUNT_MAX) begin
      byte_count <= byte_count + 3'h1;
    end
  end

  // Session enable survives select; only reset ends the session
  always_ff @(posedge clk) begin
    if (reset) begin
      enabled <= 1'b0;
    end else if (rise && state == ST_ENABLE && pins.data == ENABLE_BYTE2) begin
      enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      command <= 8'h00;
    end else if (rise && state == ST_COMMAND) begin
      command <= pins.data;
    end
  end

  // Address capture and offset walk
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_high <= 8'h00;
      page      <= '0;
      offset    <= '0;
    end else if (rise && state == ST_ADDRESS && byte_count == BYTE_ADDR_HI) begin
      addr_high <= pins.data;
    end else if (rise && state == ST_ADDRESS && byte_count == BYTE_ADDR_LO) begin
      page   <= {addr_high[PAGE_HI-8:0], pins.data[7:PAGE_LO]};
      offset <= pins.data[OFFSET_HI:0];
    end else if (fall && state == ST_DATA && byte_count > BYTE_FIRST_DATA) begin
      offset <= offset + 5'h01;
    end
  end

  // Page buffer fill; writes land at consecutive offsets only
  always_ff @(posedge clk) begin
    if (reset || prog_start) begin
      buf_valid <= '0;
    end else if (rise && state == ST_DATA &&
                 (command == CMD_WRITE_CODE || command == CMD_WRITE_USER)) begin
      page_buf[offset]  <= pins.data;
      buf_valid[offset] <= 1'b1;
    end
  end

  // Lock and fuse frames carry a single data byte
  always_ff @(posedge clk) begin
    if (reset) begin
      held_byte <= 8'h00;
    end else if (rise && state == ST_DATA && byte_count == BYTE_FIRST_DATA) begin
      held_byte <= pins.data;
    end
  end

  // Commit is armed by the frame, fired by select rising
  always_ff @(posedge clk) begin
    if (reset || prog_start) begin
      pending <= 1'b0;
    end else if (rise && state == ST_ADDRESS && byte_count == BYTE_ADDR_LO &&
                 (command == CMD_WRITE_CODE || command == CMD_WRITE_USER)) begin
      pending <= 1'b1;
    end else if (rise && state == ST_DATA && byte_count == BYTE_FIRST_DATA &&
                 (command == CMD_WRITE_LOCK || command == CMD_WRITE_FUSE)) begin
      pending <= 1'b1;
    end
  end

  assign prog_start = select_rise & pending;

  // Code array commit: only buffered offsets are programmed
  always_ff @(posedge clk) begin
    if (prog_start && command == CMD_WRITE_CODE) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (buf_valid[i]) begin
          code_mem[{page, 5'(i)}] <= page_buf[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (prog_start && command == CMD_WRITE_USER) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (buf_valid[i]) begin
          user_row[i] <= page_buf[i];
        end
      end
    end
  end

  // Lock bits can only be programmed towards locked
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_bits <= LOCK_RESET;
      fuses     <= FUSE_RESET;
    end else if (prog_start && command == CMD_WRITE_LOCK) begin
      lock_bits <= lock_bits & held_byte[1:0];
    end else if (prog_start && command == CMD_WRITE_FUSE) begin
      fuses <= held_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      success <= 1'b0;
    end else if (prog_start) begin
      success <= 1'b0;
    end else if (prog_done) begin
      success <= 1'b1;
    end
  end

  always_comb begin
    status_byte                     = 8'h00;
    status_byte[STATUS_BUSY_BIT]    = ~busy;
    status_byte[STATUS_WRTINH_BIT]  = 1'b1;
    status_byte[STATUS_SUCCESS_BIT] = success;
    status_byte[STATUS_LOAD_BIT]    = 1'b1;
  end

  always_comb begin
    case (command)
      CMD_READ_CODE:   read_byte = code_mem[{page, offset}];
      CMD_READ_USER:   read_byte = user_row[offset];
      CMD_READ_MAKER:  read_byte = maker_row[offset];
      CMD_READ_LOCK:   read_byte = {LOCK_PAD, lock_bits};
      CMD_READ_FUSE:   read_byte = fuses;
      CMD_READ_STATUS: read_byte = status_byte;
      default:         read_byte = 8'h00;
    endcase
  end

  // Port driver; output enabled until select rises, data tracks read_byte each clock
  always_ff @(posedge clk) begin
    if (reset || pins.select_n) begin
      byte_command_port_oe_n <= 1'b1;
    end else if (fall && state == ST_DATA && byte_count == BYTE_FIRST_DATA && is_read) begin
      byte_command_port_oe_n <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      byte_command_port_out <= 8'h00;
    end else begin
      byte_command_port_out <= read_byte;
    end
  end

  // Busy is not gated by the select level; it goes low after the select rise that fires a commit
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_busy_pin <= 1'b1;
    end else begin
      ready_busy_pin <= ~(busy | prog_start);
    end
  end

endmodule : pfpp_flash_port

// ==== design/pfpp_pkg.sv ====
// Constants and types of the byte-wide flash programming port.
// Assumes a single 25 MHz system clock; all pins arrive asynchronously.
package pfpp_pkg;

  // Command stream bytes
  localparam logic [7:0] PREAMBLE        = 8'hAA;
  localparam logic [7:0] ENABLE_BYTE1    = 8'hAC;
  localparam logic [7:0] ENABLE_BYTE2    = 8'h53;
  localparam logic [7:0] CMD_WRITE_CODE  = 8'h50;
  localparam logic [7:0] CMD_READ_CODE   = 8'h30;
  localparam logic [7:0] CMD_WRITE_USER  = 8'h52;
  localparam logic [7:0] CMD_READ_USER   = 8'h32;
  localparam logic [7:0] CMD_READ_MAKER  = 8'h38;
  localparam logic [7:0] CMD_WRITE_LOCK  = 8'hE4;
  localparam logic [7:0] CMD_READ_LOCK   = 8'h64;
  localparam logic [7:0] CMD_WRITE_FUSE  = 8'hE1;
  localparam logic [7:0] CMD_READ_FUSE   = 8'h61;
  localparam logic [7:0] CMD_READ_STATUS = 8'h60;

  // Array geometry and address fields
  localparam int CODE_BYTES = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_HI    = 11;
  localparam int PAGE_LO    = 5;
  localparam int OFFSET_HI  = 4;

  // Byte positions within a command frame
  localparam logic [2:0] BYTE_ADDR_HI    = 3'h2;
  localparam logic [2:0] BYTE_ADDR_LO    = 3'h3;
  localparam logic [2:0] BYTE_FIRST_DATA = 3'h4;
  localparam logic [2:0] BYTE_COUNT_MAX  = 3'h7;

  // Reset values
  localparam logic [7:0] FUSE_RESET = 8'hFF;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [5:0] LOCK_PAD   = 6'h3F;

  // Field positions
  localparam int FUSE_USER_ROW_BIT = 0;
  localparam int STATUS_BUSY_BIT   = 0;
  localparam int STATUS_WRTINH_BIT = 1;
  localparam int STATUS_SUCCESS_BIT = 2;
  localparam int STATUS_LOAD_BIT   = 3;

  // Arbitrary value, seeds the maker signature row
  localparam logic [7:0] MAKER_SIG_SEED = 8'h5A;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_TIME_NS = 4500000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

  // Pin group after synchronisation
  typedef struct packed {
    logic       strobe;
    logic       select_n;
    logic [7:0] data;
  } pfpp_pins_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREAMBLE,
    ST_COMMAND,
    ST_ENABLE,
    ST_ADDRESS,
    ST_DATA,
    ST_IGNORE
  } pfpp_state_type;

endpackage : pfpp_pkg

// ==== design/pfpp_sync.sv ====
// Two-flop synchroniser, one stage pair per bit.
// Assumes async_in changes slowly relative to clk.
`timescale 1ns/1ps
module pfpp_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      // First stage is read by the second stage only
      always_ff @(posedge clk) begin
        if (reset) begin
          meta        <= RESET_VALUE[i];
          sync_out[i] <= RESET_VALUE[i];
        end else begin
          meta        <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule : pfpp_sync

// ==== design/pfpp_busy_timer.sv ====
// Programming cycle timer: busy for CYCLES clocks after start.
// Assumes start never arrives while busy.
`timescale 1ns/1ps
module pfpp_busy_timer #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] remaining;

  always_ff @(posedge clk) begin
    if (reset) begin
      remaining <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remaining <= LOAD;
        busy      <= 1'b1;
      end else if (busy) begin
        if (remaining == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remaining <= remaining - CW'(1);
        end
      end
    end
  end

endmodule : pfpp_busy_timer

// ==== test/pfpp_properties.sv ====
// Pin-level assertions for the flash programming port.
// Bound to pfpp_flash_port by the bench; one clock domain.
`timescale 1ns/1ps
module pfpp_properties #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Programmer side
  input wire logic       byte_strobe_pin,
  input wire logic       select_pin_n,
  // Device side
  input wire logic [7:0] byte_command_port_out,
  input wire logic       byte_command_port_oe_n,
  input wire logic       ready_busy_pin
);
  logic [15:0] low_cnt;
  logic [3:0]  hi_cnt;
  logic [3:0]  sel_cnt;

  always_ff @(posedge clk) begin
    if (reset || ready_busy_pin) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  // Saturating, so long pulses never wrap back to small counts
  always_ff @(posedge clk) begin
    hi_cnt <= !byte_strobe_pin ? 4'h0 : (hi_cnt == 4'hF ? hi_cnt : hi_cnt + 4'h1);
  end

  always_ff @(posedge clk) begin
    sel_cnt <= select_pin_n ? 4'h0 : (sel_cnt == 4'hF ? sel_cnt : sel_cnt + 4'h1);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_RESET_IDLE: assert property (disable iff (1'b0)
    reset |=> byte_command_port_oe_n && ready_busy_pin && byte_command_port_out == 8'h00)
    else $error("outputs not idle after reset");
  AST_RELEASE_ON_SELECT: assert property (
    select_pin_n [*5] |-> byte_command_port_oe_n)
    else $error("port still driven with select high");
  AST_DATA_HOLDS: assert property (
    !byte_command_port_oe_n && sel_cnt == 4'hF |=> !byte_command_port_oe_n)
    else $error("port released while select low");
  AST_DRIVE_AFTER_FALL: assert property (
    $fell(byte_command_port_oe_n) |-> !$past(byte_strobe_pin, 2) && !select_pin_n)
    else $error("port driven before strobe fall");
  AST_OUT_STEADY: assert property (
    hi_cnt >= 4'h5 && !byte_command_port_oe_n && !$past(byte_command_port_oe_n)
      |-> $stable(byte_command_port_out))
    else $error("read data moved while strobe high");
  AST_BUSY_AT_CLOSE: assert property (
    $fell(ready_busy_pin) |-> select_pin_n)
    else $error("busy began inside a frame");
  AST_BUSY_SPAN: assert property (
    $rose(ready_busy_pin) |-> low_cnt >= PROG_CYCLES)
    else $error("busy ended early");
  AST_BUSY_BOUND: assert property (
    low_cnt <= PROG_CYCLES + 2)
    else $error("busy lasted too long");

  cover property ($fell(byte_command_port_oe_n));
  cover property ($rose(ready_busy_pin));
  cover property (!byte_command_port_oe_n && $changed(byte_command_port_out));
endmodule : pfpp_properties

// ==== test/pfpp_programmer.sv ====
// Device programmer model: select, strobe and the shared byte port.
// Resolves the port from both enables; drives pins at the falling clock.
`timescale 1ns/1ps
module pfpp_programmer
  import pfpp_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Device side of the port
  input  wire logic [7:0] dev_out,
  input  wire logic       dev_oe_n,
  // Pins seen by the device
  output pfpp_pins_type   pins
);
  logic       drive = 1'b0;
  logic [7:0] drv   = 8'h00;
  logic [7:0] last  = 8'h00;
  logic       stb   = 1'b0;
  logic       sel_n = 1'b1;

  // A floating port toggles so no stale byte can pass for data
  always_comb pins = '{strobe: stb, select_n: sel_n,
                       data: drive ? drv : (!dev_oe_n ? dev_out : ~last)};
  always @(posedge clk) last <= pins.data;

  task automatic open;
    @(negedge clk) sel_n = 1'b0;
    repeat (3) @(negedge clk);
  endtask : open

  task automatic close;
    @(negedge clk) drive = 1'b0;
    sel_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : close

  // Mode 0 drives, 1 releases before the fall, 2 never drives
  task automatic pulse(input logic [7:0] d, input logic [1:0] mode);
    @(negedge clk);
    drv = d;
    drive = (mode != 2'h2);
    @(negedge clk) stb = 1'b1;
    repeat (5) @(negedge clk);
    if (mode == 2'h1) drive = 1'b0;
    @(negedge clk) stb = 1'b0;
    repeat (5) @(negedge clk);
  endtask : pulse
endmodule : pfpp_programmer

// ==== test/pfpp_flash_port_tb.sv ====
// Self-checking bench for the flash programming port.
// Programmer model drives the pins; bench owns clock and reset.
`timescale 1ns/1ps
module pfpp_flash_port_tb
  import pfpp_pkg::*;
;
  localparam int PROG = 100;
  logic          clk   = 1'b0;
  logic          reset = 1'b1;
  logic [7:0]    dout;
  logic          oe_n;
  logic          rb;
  pfpp_pins_type pins;
  int            failures = 0;
  int            num_checks = 0;
  logic [7:0]    mem [32];

  always #20 clk = ~clk;

  pfpp_programmer p (.clk(clk), .dev_out(dout), .dev_oe_n(oe_n), .pins(pins));
  pfpp_flash_port #(.PROG_CYCLES(PROG)) dut (
    .clk(clk), .reset(reset), .byte_strobe_pin(pins.strobe),
    .select_pin_n(pins.select_n), .byte_command_port_in(pins.data),
    .byte_command_port_out(dout), .byte_command_port_oe_n(oe_n),
    .ready_busy_pin(rb));

  function automatic logic [4:0] nxt(input logic [7:0] a, input int i);
    return 5'(int'(a[4:0]) + i);
  endfunction : nxt

  // Undriven port reads as X, which only an X expectation matches
  function automatic logic [7:0] port();
    return oe_n === 1'b0 ? dout : 8'hXX;
  endfunction : port

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic hdr(input logic [7:0] c, b2, b3, input logic rd);
    p.open;
    p.pulse(PREAMBLE, 2'h0);
    p.pulse(c, 2'h0);
    p.pulse(b2, 2'h0);
    p.pulse(b3, {1'b0, rd});
  endtask : hdr

  task automatic prog_wait(input logic busy_exp);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < PROG + 20; n++) begin
      @(negedge clk);
      if (!rb) seen = 1'b1;
      if (seen && rb) break;
    end
    chk({7'h0, seen}, {7'h0, busy_exp});
    repeat (80) @(negedge clk);
  endtask : prog_wait

  task automatic wr(input logic [7:0] c, b2, b3, input int n);
    hdr(c, b2, b3, 1'b0);
    for (int i = 0; i < n; i++) begin
      mem[nxt(b3, i)] = 8'($urandom);
      p.pulse(mem[nxt(b3, i)], 2'h0);
    end
    p.close;
    prog_wait(1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] c, b2, b3, input int n);
    hdr(c, b2, b3, 1'b1);
    for (int i = 0; i < n; i++) begin
      if (i > 0) p.pulse(8'h00, 2'h2);
      chk(port(), mem[nxt(b3, i)]);
    end
    p.close;
  endtask : rd

  task automatic rd1(input logic [7:0] c, input logic [7:0] exp);
    hdr(c, 8'h00, 8'h00, 1'b1);
    chk(port(), exp);
    p.close;
  endtask : rd1

  initial begin
    logic [6:0] pg;
    logic [7:0] lo;
    int         n;
    void'($urandom(2203));
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk(dout, 8'h00);
    chk({6'h00, oe_n, rb}, 8'h03);
    rd1(CMD_READ_FUSE, 8'hXX);
    p.open;
    p.pulse(PREAMBLE, 2'h0);
    p.pulse(ENABLE_BYTE1, 2'h0);
    p.pulse(ENABLE_BYTE2, 2'h0);
    p.close;
    rd1(8'h77, 8'hXX);
    hdr(CMD_READ_STATUS, 8'h00, 8'h00, 1'b1);
    chk(port() & 8'hFB, 8'h0B);
    p.close;
    rd1(CMD_READ_FUSE, FUSE_RESET);
    rd1(CMD_READ_LOCK, {LOCK_PAD, LOCK_RESET});
    hdr(CMD_WRITE_USER, 8'h00, 8'h05, 1'b0);
    p.pulse(8'h3C, 2'h0);
    p.close;
    prog_wait(1'b0);
    hdr(CMD_WRITE_FUSE, 8'h00, 8'h00, 1'b0);
    p.pulse(8'hFE, 2'h0);
    p.close;
    prog_wait(1'b1);
    rd1(CMD_READ_FUSE, 8'hFE);
    wr(CMD_WRITE_USER, 8'h00, 8'h1E, 3);
    rd(CMD_READ_USER, 8'h00, 8'h1E, 3);
    for (int i = 0; i < 32; i++) mem[i] = MAKER_SIG_SEED + 8'(i);
    rd(CMD_READ_MAKER, 8'h00, 8'h1E, 4);
    for (int k = 0; k < 3; k++) begin
      pg = 7'($urandom);
      lo = {pg[2:0], k == 0 ? 5'h1F : 5'($urandom)};
      n = 2 + int'($urandom % 7);
      wr(CMD_WRITE_CODE, {4'h0, pg[6:3]}, lo, n);
      rd(CMD_READ_CODE, {4'h0, pg[6:3]}, lo, n);
    end
    wr(CMD_WRITE_CODE, {4'h0, pg[6:3]}, lo, 0);
    rd(CMD_READ_CODE, {4'h0, pg[6:3]}, lo, n);
    hdr(CMD_WRITE_LOCK, 8'h00, 8'h00, 1'b0);
    p.pulse(8'hFE, 2'h0);
    p.close;
    rd1(CMD_READ_STATUS, 8'h0A);
    prog_wait(1'b1);
    rd1(CMD_READ_LOCK, 8'hFE);
    summarize;
  end

  initial begin
    #(40 * 20000);
    failures++;
    summarize;
  end
endmodule : pfpp_flash_port_tb

bind pfpp_flash_port pfpp_properties #(.PROG_CYCLES(PROG_CYCLES)) props (
  .clk(clk), .reset(reset), .byte_strobe_pin(byte_strobe_pin),
  .select_pin_n(select_pin_n), .byte_command_port_out(byte_command_port_out),
  .byte_command_port_oe_n(byte_command_port_oe_n), .ready_busy_pin(ready_busy_pin));
